// ---- rtl/sebs_ctrl.sv ----
// Shared external bus strobe, suspend and host request controller
`timescale 1ns/10ps
// Summary of operation
// - Read strobe low during external reads and internal-memory reads.
// - Write strobe low during external writes and internal-memory writes.
// - Only the bus master drives read and write strobes; others input them.
// - Page flag asserts when an external access crosses a DRAM page.
// - Page flag only for bank 0 accesses, driven only by the master.
// - Only the bus master drives the clock reference output.
// - Sync write select low early; write abandoned if strobe never follows.
// - Sync write select asserted in the same cycle as the address.
// - Master drives sync write select; slaves sample it for read/write.
// - Device drives acknowledge low to stretch accesses to its memory.
// - Master keeps acknowledge input at last driven level via a keeper.
// - Suspend-bus low floats address, data, selects, strobes three cycles later.
// - Access attempted under suspend-bus stalls until it is released.
// - On host request, master floats bus lines, then asserts grant.
// - Host bus request outranks every multiprocessor bus request.
// - Host bus grant held low until the host releases its request.
module sebs_ctrl
  import sebs_pkg::*;
#(
  parameter int ADDR_W = SEBS_ADDR_W,
  parameter int MS_W = SEBS_MS_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Core side
  input wire sebs_req_t core_req,
  input wire logic is_master,
  input wire logic [SEBS_PAGE_BITS_W-1:0] page_bits,
  input wire logic [MS_W-1:0] bank_sel,
  output logic core_done,
  output logic core_stall,
  output logic [SEBS_MP_REQ_W-1:0] mp_grant_block,
  // Internal memory busy, slave side wait request
  input wire logic mem_wait,
  output logic slave_access,
  output logic slave_write,
  // Pin inputs
  input wire logic rd_in_n,
  input wire logic wr_in_n,
  input wire logic sw_in_n,
  input wire logic ack_in,
  input wire logic suspend_bus_float_n,
  input wire logic host_bus_request_n,
  input wire logic [SEBS_MP_REQ_W-1:0] mp_bus_request_n,
  // Pin outputs
  output sebs_pins_t bus_out,
  output logic bus_oe,
  output logic bus_clock_ref_out,
  output logic bus_clock_ref_oe,
  output logic ack_out,
  output logic ack_oe,
  output logic host_bus_grant_n
);
  // Bank selects map straight onto the pin struct, so widths must agree
  if (MS_W != SEBS_MS_W || ADDR_W < 8 ||
      ADDR_W > SEBS_ADDR_W) begin : g_bad_width
    $error("sebs_ctrl: unsupported width");
  end

  logic rd_s_n;
  logic wr_s_n;
  logic sw_s_n;
  logic ack_s;
  logic suspend_bus_float_n_s_n;
  logic hbr_s_n;
  logic crossed;
  logic issue;
  sebs_state_t state;
  sebs_state_t next_state;
  sebs_pins_t next_bus_out;
  logic next_bus_oe;
  logic next_core_done;
  logic next_core_stall;
  logic next_grant_n;
  logic [1:0] ack_age;
  logic [1:0] next_ack_age;
  logic next_ack_out;
  logic next_ack_oe;
  logic ack_keep;
  logic next_ack_keep;
  logic slv_sw_n;
  logic next_slv_sw_n;
  logic next_slave_access;
  logic next_slave_write;
  logic [3:0] div_cnt;
  logic [3:0] next_div_cnt;
  logic next_clkref;
  logic next_clkref_oe;
  logic [SEBS_MP_REQ_W-1:0] next_mp_block;

  // Pins from outside the clock domain: two flops each
  sebs_sync #(.WIDTH(6), .RST_VAL(6'h3f)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .d({rd_in_n, wr_in_n, sw_in_n, ack_in, suspend_bus_float_n,
        host_bus_request_n}),
    .q({rd_s_n, wr_s_n, sw_s_n, ack_s, suspend_bus_float_n_s_n, hbr_s_n})
  );

  assign issue = (state == SEBS_IDLE) && core_req.valid && is_master &&
                 !core_req.internal_target && suspend_bus_float_n_s_n && hbr_s_n;

  sebs_page_det #(.ADDR_W(ADDR_W)) u_page (
    .mclk(mclk),
    .reset_n(reset_n),
    .issue(issue),
    .bank0(bank_sel[SEBS_DRAM_BANK]),
    .addr(core_req.addr[ADDR_W-1:0]),
    .page_bits(page_bits),
    .crossed(crossed)
  );

  // Master access sequencer
  always_comb begin
    next_state = state;
    next_bus_out = bus_out;
    next_bus_oe = bus_oe;
    next_core_done = 1'b0;
    next_core_stall = 1'b0;
    next_grant_n = host_bus_grant_n;
    next_ack_age = 2'h0;
    unique case (state)
      SEBS_IDLE: begin
        next_bus_out.rd_n = SEBS_STROBE_IDLE;
        next_bus_out.wr_n = SEBS_STROBE_IDLE;
        next_bus_out.sw_n = SEBS_STROBE_IDLE;
        next_bus_out.page = 1'b0;
        next_bus_out.ms_n = '1;
        next_bus_oe = is_master && suspend_bus_float_n_s_n;
        if (!hbr_s_n && is_master) begin
          // Host wins over any pending core access
          next_bus_oe = 1'b0;
          next_state = SEBS_HOST_GRANT;
        end else if (core_req.valid && is_master && !suspend_bus_float_n_s_n) begin
          next_core_stall = 1'b1;
          next_state = SEBS_WAIT_SUSPEND;
        end else if (issue) begin
          next_bus_out.addr = core_req.addr;
          next_bus_out.data = core_req.wdata;
          next_bus_out.ms_n = ~bank_sel;
          next_bus_out.sw_n = !core_req.write;
          next_bus_out.page = crossed;
          next_core_stall = 1'b1;
          next_state = SEBS_ADDR;
        end else if (core_req.valid && core_req.internal_target) begin
          // Internal memory of a sibling core is accessed over the bus
          next_bus_out.addr = core_req.addr;
          next_bus_out.data = core_req.wdata;
          next_core_stall = 1'b1;
          next_state = SEBS_STROBE;
          if (core_req.write && !core_req.cond_ok) begin
            // Failed conditional write: finish with no strobe
            next_core_stall = 1'b0;
            next_core_done = 1'b1;
            next_state = SEBS_IDLE;
          end else begin
            next_bus_out.rd_n = core_req.write;
            next_bus_out.wr_n = !core_req.write;
          end
        end
      end
      SEBS_ADDR: begin
        next_core_stall = 1'b1;
        if (!suspend_bus_float_n_s_n) begin
          next_bus_oe = 1'b0;
          next_state = SEBS_WAIT_SUSPEND;
        end else if (core_req.write && !core_req.cond_ok) begin
          // Failed conditional write: strobe never follows
          next_bus_out.sw_n = SEBS_STROBE_IDLE;
          next_core_stall = 1'b0;
          next_core_done = 1'b1;
          next_state = SEBS_IDLE;
        end else begin
          next_bus_out.rd_n = core_req.write;
          next_bus_out.wr_n = !core_req.write;
          next_state = SEBS_STROBE;
        end
      end
      SEBS_STROBE: begin
        next_core_stall = 1'b1;
        // Synced acknowledge lags the pin; skip it until it reflects this
        // strobe, so a late ready of the last access cannot end it
        next_ack_age = ack_age + {1'b0, ~&ack_age};
        if (!suspend_bus_float_n_s_n) begin
          next_bus_oe = 1'b0;
          next_state = SEBS_WAIT_SUSPEND;
        end else if (ack_keep && (&ack_age)) begin
          // Low acknowledge holds the strobe as wait states
          next_bus_out.rd_n = SEBS_STROBE_IDLE;
          next_bus_out.wr_n = SEBS_STROBE_IDLE;
          next_bus_out.sw_n = SEBS_STROBE_IDLE;
          next_bus_out.page = 1'b0;
          next_core_stall = 1'b0;
          next_core_done = 1'b1;
          next_state = SEBS_IDLE;
        end
      end
      SEBS_WAIT_SUSPEND: begin
        next_core_stall = 1'b1;
        next_bus_oe = 1'b0;
        next_bus_out.rd_n = SEBS_STROBE_IDLE;
        next_bus_out.wr_n = SEBS_STROBE_IDLE;
        next_bus_out.sw_n = SEBS_STROBE_IDLE;
        next_bus_out.ms_n = '1;
        if (suspend_bus_float_n_s_n) begin
          // Access restarts from the top once released
          next_core_stall = 1'b0;
          next_state = SEBS_IDLE;
        end
      end
      SEBS_HOST_GRANT: begin
        next_bus_oe = 1'b0;
        next_core_stall = core_req.valid;
        next_grant_n = hbr_s_n;
        if (hbr_s_n) begin
          next_state = SEBS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= SEBS_IDLE;
      bus_out <= '{addr: '0, data: '0, ms_n: '1, rd_n: 1'b1, wr_n: 1'b1,
                   sw_n: 1'b1, page: 1'b0};
      bus_oe <= 1'b0;
      core_done <= 1'b0;
      core_stall <= 1'b0;
      host_bus_grant_n <= 1'b1;
      ack_age <= 2'h0;
    end else begin
      state <= next_state;
      bus_out <= next_bus_out;
      bus_oe <= next_bus_oe;
      core_done <= next_core_done;
      core_stall <= next_core_stall;
      host_bus_grant_n <= next_grant_n;
      ack_age <= next_ack_age;
    end
  end

  // Slave side, acknowledge keeper, clock reference, arbitration block
  always_comb begin
    next_slv_sw_n = sw_s_n;
    // Slave decodes direction from sync write select and strobes
    next_slave_access = !is_master && (!rd_s_n || !wr_s_n);
    next_slave_write = !is_master && (!wr_s_n || !slv_sw_n);
    // Keeper holds the last driven level of the acknowledge input
    next_ack_keep = ack_oe ? ack_out : ack_s;
    // As slave, pull acknowledge low while our memory is busy
    next_ack_oe = !is_master && next_slave_access && mem_wait;
    next_ack_out = 1'b0;
    if (!next_ack_oe && ack_oe) begin
      // Drive high one cycle before release so the keeper sees ready
      next_ack_oe = 1'b1;
      next_ack_out = 1'b1;
      if (ack_out) begin
        next_ack_oe = 1'b0;
      end
    end
    next_div_cnt = div_cnt + 4'h1;
    next_clkref = bus_clock_ref_out;
    if (div_cnt >= SEBS_CLKREF_DIV) begin
      next_div_cnt = 4'h0;
      next_clkref = !bus_clock_ref_out;
    end
    next_clkref_oe = is_master && suspend_bus_float_n_s_n && hbr_s_n;
    // While host owns the bus, no peer request may be honoured
    next_mp_block = hbr_s_n ? ~mp_bus_request_n & '0 : '1;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      slv_sw_n <= 1'b1;
      slave_access <= 1'b0;
      slave_write <= 1'b0;
      ack_keep <= 1'b1;
      ack_out <= 1'b1;
      ack_oe <= 1'b0;
      div_cnt <= 4'h0;
      bus_clock_ref_out <= 1'b0;
      bus_clock_ref_oe <= 1'b0;
      mp_grant_block <= '0;
    end else begin
      slv_sw_n <= next_slv_sw_n;
      slave_access <= next_slave_access;
      slave_write <= next_slave_write;
      ack_keep <= next_ack_keep;
      ack_out <= next_ack_out;
      ack_oe <= next_ack_oe;
      div_cnt <= next_div_cnt;
      bus_clock_ref_out <= next_clkref;
      bus_clock_ref_oe <= next_clkref_oe;
      mp_grant_block <= next_mp_block;
    end
  end
endmodule // sebs_ctrl

// ---- rtl/sebs_pkg.sv ----
// Package of constants and carrier types for the shared external bus control
package sebs_pkg;
  localparam int SEBS_ADDR_W = 32;
  localparam int SEBS_DATA_W = 48;
  localparam int SEBS_MS_W = 4;
  localparam int SEBS_CORES = 4;
  localparam int SEBS_MP_REQ_W = 6;
  // Page size field width: page size is 2**page_bits words
  localparam int SEBS_PAGE_BITS_W = 5;
  localparam logic [4:0] SEBS_PAGE_BITS_RST = 5'h08;
  // DRAM lives only in bank 0
  localparam int SEBS_DRAM_BANK = 0;
  // Bus clock reference divider: one toggle per this many plus one mclk cycles
  localparam logic [3:0] SEBS_CLKREF_DIV = 4'h1;
  // Reset values of active-low strobes
  localparam logic SEBS_STROBE_IDLE = 1'b1;

  typedef enum logic [2:0] {
    SEBS_IDLE,
    SEBS_ADDR,
    SEBS_STROBE,
    SEBS_WAIT_SUSPEND,
    SEBS_HOST_GRANT
  } sebs_state_t;

  // Access request from an internal core
  typedef struct packed {
    logic valid;
    logic write;
    logic cond_ok;
    logic [SEBS_ADDR_W-1:0] addr;
    logic [SEBS_DATA_W-1:0] wdata;
    logic internal_target;
  } sebs_req_t;

  // Bus pin outputs driven by the master
  typedef struct packed {
    logic [SEBS_ADDR_W-1:0] addr;
    logic [SEBS_DATA_W-1:0] data;
    logic [SEBS_MS_W-1:0] ms_n;
    logic rd_n;
    logic wr_n;
    logic sw_n;
    logic page;
  } sebs_pins_t;
endpackage

// ---- rtl/sebs_sync.sv ----
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module sebs_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule // sebs_sync

// ---- rtl/sebs_page_det.sv ----
// DRAM page boundary detector for bank 0 accesses
`timescale 1ns/10ps
module sebs_page_det
  import sebs_pkg::*;
#(
  parameter int ADDR_W = SEBS_ADDR_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Access being issued
  input wire logic issue,
  input wire logic bank0,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [SEBS_PAGE_BITS_W-1:0] page_bits,
  // Boundary crossed, combinational with issue
  output logic crossed
);
  logic [ADDR_W-1:0] last_page;
  logic last_valid;
  logic [ADDR_W-1:0] next_last_page;
  logic next_last_valid;
  logic [ADDR_W-1:0] cur_page;

  always_comb begin
    cur_page = addr >> page_bits;
    next_last_page = last_page;
    next_last_valid = last_valid;
    crossed = 1'b0;
    if (issue && bank0) begin
      crossed = !last_valid || (cur_page != last_page);
      next_last_page = cur_page;
      next_last_valid = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      last_page <= '0;
      last_valid <= 1'b0;
    end else begin
      last_page <= next_last_page;
      last_valid <= next_last_valid;
    end
  end
endmodule // sebs_page_det

// ---- test/sebs_ctrl_chk.sv ----
// Port checker for the shared bus controller
`timescale 1ns/10ps
module sebs_ctrl_chk
  import sebs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Watched ports
  input wire sebs_req_t core_req,
  input wire logic is_master,
  input wire logic [SEBS_MS_W-1:0] bank_sel,
  input wire logic core_done,
  input wire logic [SEBS_MP_REQ_W-1:0] mp_grant_block,
  input wire logic suspend_bus_float_n,
  input wire logic host_bus_request_n,
  input wire sebs_pins_t bus_out,
  input wire logic bus_oe,
  input wire logic bus_clock_ref_oe,
  input wire logic host_bus_grant_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  chk_grant_held:
    assert property ((!host_bus_grant_n && !host_bus_request_n)[*3]
      |=> !host_bus_grant_n) else $error("grant dropped early");
  chk_grant_float:
    assert property (!host_bus_grant_n |-> !bus_oe)
      else $error("bus driven under grant");
  chk_host_first:
    assert property (!host_bus_grant_n |-> mp_grant_block == '1)
      else $error("peer requests not blocked");
  chk_sw_addr:
    assert property ($fell(bus_out.sw_n) |-> bus_oe && core_req.write)
      else $error("write select without address");
  chk_sw_then_wr:
    assert property ($fell(bus_out.sw_n) && core_req.cond_ok
      |=> !bus_out.wr_n) else $error("write strobe missing");
  chk_suspend_float:
    assert property ((!suspend_bus_float_n)[*3] |=> !bus_oe)
      else $error("bus not floated");
  chk_page_bank0:
    assert property (bus_oe && bus_out.page |-> bank_sel[0])
      else $error("page flag outside bank 0");
  chk_slave_quiet:
    assert property ((!is_master)[*2] |-> !bus_oe && !bus_clock_ref_oe)
      else $error("slave drives bus");
  chk_rd_read:
    assert property (bus_oe && !bus_out.rd_n |-> !core_req.write)
      else $error("read strobe on write");
  chk_done_bound:
    assert property ($fell(bus_out.rd_n) |-> ##[1:30] core_done)
      else $error("read never completed");
  chk_stall_hold:
    assert property ((!suspend_bus_float_n)[*4] |-> !core_done)
      else $error("done while suspended");
endmodule // sebs_ctrl_chk

bind sebs_ctrl sebs_ctrl_chk chk_u (.mclk(mclk), .reset_n(reset_n),
  .core_req(core_req), .is_master(is_master), .bank_sel(bank_sel),
  .core_done(core_done), .mp_grant_block(mp_grant_block),
  .suspend_bus_float_n(suspend_bus_float_n),
  .host_bus_request_n(host_bus_request_n), .bus_out(bus_out),
  .bus_oe(bus_oe), .bus_clock_ref_oe(bus_clock_ref_oe),
  .host_bus_grant_n(host_bus_grant_n));

// ---- test/sebs_mem_model.sv ----
// Far-side memory model that stretches strobed accesses
`timescale 1ns/10ps
module sebs_mem_model
  import sebs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Bus seen by the memory
  input wire sebs_pins_t bus_out,
  input wire logic bus_oe,
  input wire logic [3:0] wait_cycles,
  // Acknowledge to the master
  output logic ack_in
);
  logic [3:0] count;
  logic strobe;
  assign strobe = bus_oe && !(bus_out.rd_n && bus_out.wr_n);
  // Ready only late in a strobe, so a stale high never ends an access
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 4'h0;
      ack_in <= 1'b0;
    end else begin
      count <= strobe ? count + 4'h1 : 4'h0;
      ack_in <= strobe && count >= wait_cycles;
    end
  end
endmodule // sebs_mem_model

// ---- test/shared_ext_bus_strobes_host_request_bench.sv ----
// Self-checking bench for the shared bus strobe controller
`timescale 1ns/10ps
module shared_ext_bus_strobes_host_request_bench;
  import sebs_pkg::*;
  logic mclk, reset_n, is_master, mem_wait, ack_in, core_done, core_stall;
  logic slave_access, slave_write, bus_oe, bus_clock_ref_out, ack_out;
  logic bus_clock_ref_oe, ack_oe, host_bus_grant_n, rd_in_n, wr_in_n;
  logic sw_in_n, suspend_bus_float_n, host_bus_request_n;
  logic saw_rd, saw_wr, saw_sw, saw_pg, ref_lvl;
  logic [SEBS_PAGE_BITS_W-1:0] page_bits;
  logic [SEBS_MS_W-1:0] bank_sel;
  logic [SEBS_MP_REQ_W-1:0] mp_grant_block, mp_bus_request_n;
  logic [3:0] wait_cycles;
  logic [31:0] lfsr, prev;
  logic [31:0] pa [4] = '{32'h10, 32'h1f, 32'h20, 32'h1000};
  logic [3:0] pb [4] = '{4'h1, 4'h1, 4'h1, 4'h2};
  sebs_req_t core_req;
  sebs_pins_t bus_out;
  int bad_count, cmp_count;

  sebs_ctrl dut_u (.mclk, .reset_n, .core_req, .is_master, .page_bits,
    .bank_sel, .core_done, .core_stall, .mp_grant_block, .mem_wait,
    .slave_access, .slave_write, .rd_in_n, .wr_in_n, .sw_in_n, .ack_in,
    .suspend_bus_float_n, .host_bus_request_n, .mp_bus_request_n,
    .bus_out, .bus_oe, .bus_clock_ref_out, .bus_clock_ref_oe, .ack_out,
    .ack_oe, .host_bus_grant_n);
  sebs_mem_model mem_u (.mclk, .reset_n, .bus_out, .bus_oe, .wait_cycles,
    .ack_in);

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic exp_pg(input logic first, b0,
                                  input logic [31:0] p, a);
    return b0 && (first || (p >> page_bits) != (a >> page_bits));
  endfunction

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  // Holds the request until done, as the core would
  task automatic acc(input logic w, c, it, input logic [31:0] a,
                     input logic [3:0] bk);
    int n;
    int ns;
    core_req = '0;
    core_req.valid = 1'b1;
    core_req.write = w;
    core_req.cond_ok = c;
    core_req.addr = a;
    core_req.internal_target = it;
    core_req.wdata = {lfsr, lfsr[15:0]};
    bank_sel = bk;
    {saw_rd, saw_wr, saw_sw, saw_pg} = 4'h0;
    n = 0;
    ns = 0;
    while (core_done !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > 60) begin
        chk(1'b0, "access hung");
        end_sim;
      end
      if (bus_oe === 1'b1 && bus_out.rd_n === 1'b0) saw_rd = 1'b1;
      if (bus_oe === 1'b1 && bus_out.wr_n === 1'b0) saw_wr = 1'b1;
      if (bus_oe === 1'b1 && bus_out.sw_n === 1'b0) saw_sw = 1'b1;
      if (bus_oe === 1'b1 && bus_out.page === 1'b1) saw_pg = 1'b1;
      if (bus_oe === 1'b1 &&
          (bus_out.rd_n === 1'b0 || bus_out.wr_n === 1'b0)) ns++;
    end
    core_req.valid = 1'b0;
    @(negedge mclk);
    chk(saw_rd === !w && saw_wr === (w && c), "strobes");
    chk(it || saw_sw === w, "write select");
    chk(!(saw_rd || saw_wr) || ns > wait_cycles, "wait states");
  endtask

  task automatic wait_grant(input logic v);
    for (int i = 0; host_bus_grant_n !== v; i++) begin
      @(negedge mclk);
      if (i > 20) begin
        chk(1'b0, "grant hung");
        end_sim;
      end
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    {reset_n, mem_wait} = 2'b00;
    {is_master, rd_in_n, wr_in_n, sw_in_n} = 4'hf;
    {suspend_bus_float_n, host_bus_request_n} = 2'b11;
    {core_req, bank_sel, mp_bus_request_n} = '0;
    page_bits = 5'h04;
    wait_cycles = 4'h1;
    lfsr = 32'h7511;
    {bad_count, cmp_count} = 0;
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 1'b1, 1'b0, pa[i], pb[i]);
      chk(saw_pg === exp_pg(i == 0, pb[i][0], prev, pa[i]), "page");
      prev = pa[i];
    end
    $display("page test done");
    for (int i = 0; i < 12; i++) begin
      lfsr = nxt(lfsr);
      wait_cycles = lfsr[3:0] & 4'h3;
      mp_bus_request_n = lfsr[9:4];
      acc(lfsr[10], lfsr[11] | lfsr[12], lfsr[13], lfsr,
          4'h2 << ({1'b0, lfsr[14]} + lfsr[15]));
      chk(saw_pg === 1'b0, "page outside bank 0");
    end
    acc(1'b1, 1'b0, 1'b0, 32'h40, 4'h2);
    chk(bus_clock_ref_oe === 1'b1, "clock ref");
    ref_lvl = bus_clock_ref_out;
    repeat (2) @(negedge mclk);
    chk(bus_clock_ref_out === !ref_lvl, "clock ref toggle");
    $display("random test done");
    wait_cycles = 4'h3;
    fork
      acc(1'b0, 1'b1, 1'b0, 32'h80, 4'h4);
      begin
        repeat (2) @(negedge mclk);
        suspend_bus_float_n = 1'b0;
        repeat (4) @(negedge mclk);
        chk(bus_oe === 1'b0 && core_stall === 1'b1, "suspend");
        suspend_bus_float_n = 1'b1;
      end
    join
    $display("suspend test done");
    host_bus_request_n = 1'b0;
    wait_grant(1'b0);
    chk(bus_oe === 1'b0 && mp_grant_block === '1, "host grant");
    repeat (5) @(negedge mclk);
    chk(host_bus_grant_n === 1'b0, "grant held");
    host_bus_request_n = 1'b1;
    wait_grant(1'b1);
    $display("host test done");
    is_master = 1'b0;
    core_req.valid = 1'b1;
    {rd_in_n, mem_wait} = 2'b01;
    repeat (6) @(negedge mclk);
    chk(bus_oe === 1'b0 && core_done === 1'b0, "slave drove bus");
    chk(bus_clock_ref_oe === 1'b0, "slave clock ref");
    chk(slave_access === 1'b1 && slave_write === 1'b0 && ack_oe === 1'b1 &&
        ack_out === 1'b0, "slave wait");
    mem_wait = 1'b0;
    @(negedge mclk);
    chk(ack_oe === 1'b1 && ack_out === 1'b1, "ack ready");
    @(negedge mclk);
    chk(ack_oe === 1'b0, "ack release");
    {rd_in_n, wr_in_n, sw_in_n} = 3'b100;
    repeat (4) @(negedge mclk);
    chk(slave_access === 1'b1 && slave_write === 1'b1,
        "slave write");
    {rd_in_n, wr_in_n, sw_in_n} = 3'b111;
    core_req.valid = 1'b0;
    $display("slave test done");
    end_sim;
  end
endmodule // shared_ext_bus_strobes_host_request_bench
